// ==== design/clock_input_activity_monitor.sv ====
/*
  Activity monitor for two reference clock inputs: a slow leaky-bucket
  monitor per input and a fast loss-of-signal monitor on the selected one.
  Assumes reference inputs and the select pin are synchronous to clk_in and
  the register port is driven by a single master on the same clock.
*/
// Function
// - each reference input has its own slow monitor and status alarm bit.
// - both buckets share size, set, clear and leak-rate registers.
// - each 128 ms window with an irregularity adds one to the bucket.
// - the bucket saturates at the programmed size.
// - fill is 8 per second; leak is fill times 1, 1/2, 1/4, 1/8.
// - a fill and a leak together perform only the fill.
// - reaching the set threshold raises the input's alarm bit.
// - the alarm holds until the level falls below the clear threshold.
// - set threshold resets to 6, giving 0.75 s to raise.
// - clear time is 2^decay times size minus clear plus one, over eight; defaults 1,8,4.
// - both slow monitors run regardless of the selected input.
// - fast monitor flags two missing cycles and holds the loop over.
// - the fast flag drives the loss-of-signal alarm pin.
// - activity on the selected input ends holdover and resumes locking.
// - switchover applies no phase compensation; the phase step passes through.
// - frequency limit defaults to plus or minus 80 ppm.
// - phase detector capture range defaults to one unit interval.
`timescale 1ns/1ps
module clock_input_activity_monitor
  import activity_monitor_pkg::*;
#(
  parameter int unsigned WINDOW_LEN = activity_monitor_pkg::WINDOW_CYCLES
)
(
  input  wire logic                                     clk_in,
  input  wire logic                                     rst_in,
  input  wire logic                                     reference_input_one_in,
  input  wire logic                                     reference_input_two_in,
  input  wire logic                                     source_select_pin_in,
  input  wire logic [activity_monitor_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [activity_monitor_pkg::DATA_W-1:0]  wr_data_in,
  input  wire logic                                     wr_in,
  input  wire logic                                     rd_in,
  output logic      [activity_monitor_pkg::DATA_W-1:0]  rd_data_out,
  output logic                                          signal_loss_alarm_pin_out,
  output logic                                          holdover_out,
  output logic                                          selected_ref_out,
  output logic      [7:0]                               freq_limit_out,
  output logic      [7:0]                               capture_range_out
);
  import activity_monitor_pkg::*;

  function automatic logic leak_due(input logic [2:0] cnt, input logic [1:0] rate);
    logic [2:0] mask;
    mask = 3'((4'h1 << rate) - 4'h1);
    return (cnt & mask) == mask;
  endfunction

  // register file
  logic [7:0]  bucket_size_q;
  logic [7:0]  upper_thr_q;
  logic [7:0]  lower_thr_q;
  logic [1:0]  decay_rate_q;
  logic [7:0]  freq_limit_q;
  logic [7:0]  capture_ui_q;
  logic [15:0] period_q;
  logic [7:0]  rd_data_q;

  wire sel_size   = addr_in == ADDR_BUCKET_SIZE;
  wire sel_upper  = addr_in == ADDR_UPPER_THR;
  wire sel_lower  = addr_in == ADDR_LOWER_THR;
  wire sel_decay  = addr_in == ADDR_DECAY_RATE;
  wire sel_flimit = addr_in == ADDR_FREQ_LIMIT;
  wire sel_capt   = addr_in == ADDR_CAPTURE_UI;
  wire sel_per_lo = addr_in == ADDR_PERIOD_LO;
  wire sel_per_hi = addr_in == ADDR_PERIOD_HI;
  wire sel_status = addr_in == ADDR_STATUS;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bucket_size_q <= RST_BUCKET_SIZE;
      upper_thr_q   <= RST_UPPER_THR;
      lower_thr_q   <= RST_LOWER_THR;
      decay_rate_q  <= RST_DECAY_RATE;
      freq_limit_q  <= RST_FREQ_LIMIT;
      capture_ui_q  <= RST_CAPTURE_UI;
      period_q      <= RST_PERIOD;
    end
    else if (wr_in)
    begin
      if (sel_size)        bucket_size_q <= wr_data_in;
      else if (sel_upper)  upper_thr_q   <= wr_data_in;
      else if (sel_lower)  lower_thr_q   <= wr_data_in;
      else if (sel_decay)  decay_rate_q  <= wr_data_in[1:0];
      else if (sel_flimit) freq_limit_q  <= wr_data_in;
      else if (sel_capt)   capture_ui_q  <= wr_data_in;
      else if (sel_per_lo) period_q[7:0]  <= wr_data_in;
      else if (sel_per_hi) period_q[15:8] <= wr_data_in;
    end
  end

  // window timer and leak divider
  logic [31:0] win_cnt_q;
  logic [2:0]  leak_cnt_q;
  wire         win_end  = win_cnt_q == 32'(WINDOW_LEN - 1);
  wire         leak_now = win_end && leak_due(leak_cnt_q, decay_rate_q);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      win_cnt_q  <= 32'h0000_0000;
      leak_cnt_q <= 3'h0;
    end
    else
    begin
      win_cnt_q  <= win_end ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
      leak_cnt_q <= win_end ? leak_cnt_q + 3'h1 : leak_cnt_q;
    end
  end

  // slow monitors, one per input
  // a window with no edge at all counts as the irregularity; both run
  // whatever is selected so the status stays current
  logic [1:0] ref_prev_q;
  logic [1:0] seen_q;
  wire  [1:0] ref_now  = {reference_input_two_in, reference_input_one_in};
  wire  [1:0] edge_now = ref_now & ~ref_prev_q;
  wire  [1:0] fill_now = {2{win_end}} & ~(seen_q | edge_now);
  wire  [1:0] alarm;
  wire  [7:0] level_one;
  wire  [7:0] level_two;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ref_prev_q <= 2'h0;
      seen_q     <= 2'h0;
    end
    else
    begin
      ref_prev_q <= ref_now;
      seen_q     <= win_end ? 2'h0 : (seen_q | edge_now);
    end
  end

  leaky_bucket bucket_one (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .fill_in      (fill_now[0]),
    .leak_in      (leak_now),
    .size_in      (bucket_size_q),
    .set_thr_in   (upper_thr_q),
    .clear_thr_in (lower_thr_q),
    .level_out    (level_one),
    .alarm_out    (alarm[0])
  );

  leaky_bucket bucket_two (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .fill_in      (fill_now[1]),
    .leak_in      (leak_now),
    .size_in      (bucket_size_q),
    .set_thr_in   (upper_thr_q),
    .clear_thr_in (lower_thr_q),
    .level_out    (level_two),
    .alarm_out    (alarm[1])
  );

  // fast monitor on the selected input
  // no compensation on switchover: the selected clock is passed as is, so
  // any phase offset between the inputs appears on the output
  fast_state_type fast_q;
  fast_state_type fast_d;
  logic [16:0]    gap_q;
  logic           los_q;
  logic           pin_q;
  logic           hold_q;
  logic           selref_q;
  logic           sel_prev_q;
  wire            sel_edge  = source_select_pin_in ? edge_now[0] : edge_now[1];
  wire            sel_level = source_select_pin_in ? ref_now[0] : ref_now[1];
  wire            switched  = source_select_pin_in != sel_prev_q;
  // the timeout follows the programmed period, so a slow reference needs its period set
  wire [16:0]     los_limit = 17'(period_q) * 17'(MISSING_CYCLES);
  wire            gap_over  = gap_q >= los_limit;

  always_comb
  begin
    fast_d = fast_q;
    case (fast_q)
      FAST_IDLE:     fast_d = sel_edge ? FAST_TRACK : FAST_IDLE;
      FAST_TRACK:    fast_d = (gap_over && !sel_edge) ? FAST_HOLDOVER : FAST_TRACK;
      FAST_HOLDOVER: fast_d = sel_edge ? FAST_TRACK : FAST_HOLDOVER;
      default:       fast_d = FAST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fast_q     <= FAST_IDLE;
      gap_q      <= 17'h00000;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      fast_q     <= fast_d;
      sel_prev_q <= source_select_pin_in;
      // restart the gap count on an edge or a switchover
      gap_q      <= (sel_edge || switched) ? 17'h00000 :
                    (gap_over ? gap_q : gap_q + 17'h00001);
    end
  end

  assign los_q = fast_q == FAST_HOLDOVER;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_q    <= 1'b0;
      hold_q   <= 1'b0;
      selref_q <= 1'b0;
    end
    else
    begin
      pin_q    <= los_q;
      hold_q   <= los_q;
      selref_q <= sel_level;
    end
  end

  // read port
  wire [7:0] status_word = {4'h0, source_select_pin_in, los_q, alarm};
  wire [7:0] rd_mux = sel_status ? status_word                    :
                      sel_size   ? bucket_size_q                  :
                      sel_upper  ? upper_thr_q                    :
                      sel_lower  ? lower_thr_q                    :
                      sel_decay  ? {6'h00, decay_rate_q}          :
                      sel_flimit ? freq_limit_q                   :
                      sel_capt   ? capture_ui_q                   :
                      sel_per_lo ? period_q[7:0]                  :
                      sel_per_hi ? period_q[15:8]                 :
                                   8'h00;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= rd_in ? rd_mux : 8'h00;
  end

  assign rd_data_out               = rd_data_q;
  assign signal_loss_alarm_pin_out = pin_q;
  assign holdover_out              = hold_q;
  assign selected_ref_out          = selref_q;
  assign freq_limit_out            = freq_limit_q;
  assign capture_range_out         = capture_ui_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence gap_expired_s;
    fast_q == FAST_TRACK && gap_over && !sel_edge;
  endsequence
  sequence flag_and_pin_s;
    los_q ##1 (signal_loss_alarm_pin_out && holdover_out);
  endsequence
  sequence edge_in_holdover_s;
    fast_q == FAST_HOLDOVER && sel_edge;
  endsequence

  los_raise_a: assert property (gap_expired_s |=> flag_and_pin_s)
    else $error("loss of signal not flagged after missing cycles");
  los_pin_a: assert property (los_q |=> signal_loss_alarm_pin_out)
    else $error("alarm pin does not follow fast flag");
  resume_lock_a: assert property (edge_in_holdover_s |=> !los_q ##1 !holdover_out)
    else $error("holdover not left on returning activity");
  window_fill_a: assert property (win_end && !seen_q[0] && !edge_now[0]
                                  && level_one < bucket_size_q
                                  |=> level_one == $past(level_one) + 8'h01)
    else $error("empty window did not fill bucket one");
  both_run_a: assert property (win_end && !seen_q[1] && !edge_now[1]
                               && level_two < bucket_size_q
                               |=> level_two == $past(level_two) + 8'h01)
    else $error("unselected input not monitored");
  leak_rate_a: assert property (win_end && decay_rate_q == 2'h0 && !fill_now[1]
                                && level_two != 8'h00
                                |=> level_two == $past(level_two) - 8'h01)
    else $error("leak missing at full rate");
  reset_clear_a: assert property (disable iff (1'b0) rst_in |=> alarm == 2'h0
                                  && level_one == 8'h00 && level_two == 8'h00)
    else $error("buckets not emptied by reset");
  status_read_a: assert property (rd_in && sel_status |=>
                                  rd_data_out[1:0] == $past(alarm))
    else $error("status read does not show alarm bits");
  route_sel_a: assert property (source_select_pin_in ##1 source_select_pin_in
                                |-> selected_ref_out == $past(reference_input_one_in))
    else $error("selected reference not passed through");

endmodule

// ==== include/activity_monitor_pkg.sv ====
/*
  Package for the clock input activity monitor: register offsets, reset
  values, field positions and timing counts.
  Assumes a 125 MHz system clock and 8-bit register data.
*/
package activity_monitor_pkg;

  localparam int unsigned CLK_KHZ         = 125000;
  localparam int unsigned WINDOW_MS       = 128;
  localparam int unsigned WINDOW_CYCLES   = WINDOW_MS * CLK_KHZ;
  localparam int unsigned FILL_PER_SEC    = 8;
  localparam int unsigned MISSING_CYCLES  = 2;

  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;

  localparam logic [7:0] ADDR_STATUS      = 8'h11;
  localparam logic [7:0] ADDR_FREQ_LIMIT  = 8'h41;
  localparam logic [7:0] ADDR_BUCKET_SIZE = 8'h50;
  localparam logic [7:0] ADDR_UPPER_THR   = 8'h51;
  localparam logic [7:0] ADDR_LOWER_THR   = 8'h52;
  localparam logic [7:0] ADDR_DECAY_RATE  = 8'h53;
  localparam logic [7:0] ADDR_CAPTURE_UI  = 8'h54;
  localparam logic [7:0] ADDR_PERIOD_LO   = 8'h55;
  localparam logic [7:0] ADDR_PERIOD_HI   = 8'h56;

  localparam int unsigned STS_ALARM_ONE   = 0;
  localparam int unsigned STS_ALARM_TWO   = 1;
  localparam int unsigned STS_LOS         = 2;
  localparam int unsigned STS_SELECT      = 3;

  localparam logic [7:0]  RST_BUCKET_SIZE = 8'h08;
  localparam logic [7:0]  RST_UPPER_THR   = 8'h06;
  localparam logic [7:0]  RST_LOWER_THR   = 8'h04;
  localparam logic [1:0]  RST_DECAY_RATE  = 2'h1;
  localparam logic [7:0]  RST_FREQ_LIMIT  = 8'h50;
  localparam logic [7:0]  RST_CAPTURE_UI  = 8'h01;
  localparam logic [15:0] RST_PERIOD      = 16'h3D09;

  typedef enum logic [1:0] {
    FAST_IDLE,
    FAST_TRACK,
    FAST_HOLDOVER
  } fast_state_type;

endpackage

// ==== design/leaky_bucket.sv ====
/*
  One leaky-bucket accumulator with its no-activity alarm.
  Assumes fill_in and leak_in are one-cycle pulses from the window timer.
*/
`timescale 1ns/1ps
module leaky_bucket
  import activity_monitor_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        fill_in,
  input  wire logic        leak_in,
  input  wire logic [7:0]  size_in,
  input  wire logic [7:0]  set_thr_in,
  input  wire logic [7:0]  clear_thr_in,
  output logic      [7:0]  level_out,
  output logic             alarm_out
);

  logic [7:0] level_q;
  logic [7:0] level_d;
  logic       alarm_q;
  logic       alarm_d;
  wire        full     = level_q >= size_in;
  wire        empty    = level_q == 8'h00;

  // a fill blocks a leak on the same window boundary
  assign level_d = (fill_in && !full)             ? level_q + 8'h01 :
                   (fill_in)                      ? level_q :
                   (leak_in && !empty)            ? level_q - 8'h01 :
                                                    level_q;
  assign alarm_d = (level_q >= set_thr_in)        ? 1'b1 :
                   (level_q <  clear_thr_in)      ? 1'b0 :
                                                    alarm_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      level_q <= 8'h00;
      alarm_q <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
      alarm_q <= alarm_d;
    end
  end

  assign level_out = level_q;
  assign alarm_out = alarm_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  bucket_sat_a: assert property (fill_in && full |=> level_q == $past(level_q))
    else $error("bucket counted past its size");
  fill_wins_a: assert property (fill_in && leak_in && !full |=>
                                level_q == $past(level_q) + 8'h01)
    else $error("leak was not suppressed by fill");
  alarm_raise_a: assert property (level_q >= set_thr_in |=> alarm_q)
    else $error("alarm not raised at set threshold");
  alarm_hold_a: assert property (alarm_q && level_q >= clear_thr_in |=> alarm_q)
    else $error("alarm dropped above clear threshold");
  alarm_clear_a: assert property (level_q < clear_thr_in && level_q < set_thr_in
                                  |=> !alarm_q)
    else $error("alarm not cleared below clear threshold");

endmodule

// ==== verif/clock_card_model.sv ====
/*
  Model of the master and slave clock cards that feed the two reference inputs.
  Assumes the monitor samples both references as synchronous levels on clk_in.
*/
`timescale 1ns/1ps
module clock_card_model #(
  parameter int unsigned HALF_PERIOD = 2
)
(
  input  wire logic clk_in,
  input  wire logic run_one_in,
  input  wire logic run_two_in,
  output logic      ref_one_out,
  output logic      ref_two_out
);
  int unsigned phase_q;
  logic        ref_q;

  initial
  begin
    phase_q = 0;
    ref_q = 1'b0;
    ref_one_out = 1'b0;
    ref_two_out = 1'b0;
  end

  // a failed card leaves its line stuck low, which is the loss being modelled
  always @(posedge clk_in)
  begin
    phase_q <= (phase_q == 2 * HALF_PERIOD - 1) ? 0 : phase_q + 1;
    ref_q <= (phase_q < HALF_PERIOD);
    ref_one_out <= run_one_in & (phase_q < HALF_PERIOD);
    // slave lags master by one cycle, far below the allowed phase spread
    ref_two_out <= run_two_in & ref_q;
  end
endmodule

// ==== verif/test_clock_input_activity_monitor.sv ====
/*
  Testbench for the clock input activity monitor: register reset values,
  slow monitor raise and clear timing for every leak rate, fast loss alarm.
  Assumes the design is built with a 16-cycle window and samples on clk.
*/
`timescale 1ns/1ps
module test_clock_input_activity_monitor;
  import activity_monitor_pkg::*;
  localparam int W = 16;
  typedef struct packed {
    logic       inp;
    logic [7:0] size;
    logic [7:0] set_thr;
    logic [7:0] clr_thr;
    logic [1:0] decay;
  } slow_row_type;
  logic [15:0]  reg_rows [10] = '{16'h1108, 16'h4150, 16'h5008, 16'h5106, 16'h5204,
                                  16'h5301, 16'h5401, 16'h5509, 16'h563D, 16'h2000};
  slow_row_type rows [4] = '{'{1'b0, 8'h08, 8'h06, 8'h04, 2'h1},
                             '{1'b1, 8'h04, 8'h03, 8'h02, 2'h0},
                             '{1'b0, 8'h05, 8'h05, 8'h02, 2'h2},
                             '{1'b1, 8'h03, 8'h02, 8'h02, 2'h3}};
  logic         clk;
  logic         rst;
  logic         run_one;
  logic         run_two;
  logic         ref_one;
  logic         ref_two;
  logic         sel;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   rdata;
  logic         los;
  logic         hold;
  logic         sref;
  logic [7:0]   flim;
  logic [7:0]   cap;
  logic [7:0]   got;
  logic         prev;
  int           fail_count;
  int           checks;
  int           cyc;
  int           t0;
  int           n;

  clock_card_model i_cards (
    .clk_in      (clk),
    .run_one_in  (run_one),
    .run_two_in  (run_two),
    .ref_one_out (ref_one),
    .ref_two_out (ref_two)
  );

  clock_input_activity_monitor #(.WINDOW_LEN(W)) i_dut (
    .clk_in                    (clk),
    .rst_in                    (rst),
    .reference_input_one_in    (ref_one),
    .reference_input_two_in    (ref_two),
    .source_select_pin_in      (sel),
    .addr_in                   (addr),
    .wr_data_in                (wdata),
    .wr_in                     (wr),
    .rd_in                     (rd),
    .rd_data_out               (rdata),
    .signal_loss_alarm_pin_out (los),
    .holdover_out              (hold),
    .selected_ref_out          (sref),
    .freq_limit_out            (flim),
    .capture_range_out         (cap)
  );

  always #4 clk = ~clk;

  always @(posedge clk)
    cyc <= cyc + 1;

  task automatic summarize;
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
    checks++;
    if (act !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // polls the status register; the window phase is unknown, so bounds span at least two windows
  task automatic wait_bit(input int b, input logic v, input int lo, input int hi,
                          input string what);
    t0 = cyc;
    got = 8'h00;
    got[b] = ~v;
    while (got[b] !== v && cyc - t0 <= hi)
      reg_rd(ADDR_STATUS, got);
    check({7'h0, (cyc - t0 >= lo && cyc - t0 <= hi + 2)}, 8'h01, what);
  endtask

  task automatic wait_los(input logic v, input int lo, input int hi, input string what);
    t0 = cyc;
    while (los !== v && cyc - t0 <= hi)
    begin
      @(posedge clk);
      #1;
    end
    check({7'h0, (cyc - t0 >= lo && cyc - t0 <= hi)}, 8'h01, what);
    check({7'h0, hold}, {7'h0, v}, "holdover follows alarm");
    @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    run_one = 1'b1;
    run_two = 1'b1;
    sel = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (reg_rows[r])
    begin
      reg_rd(reg_rows[r][15:8], got);
      check(got, reg_rows[r][7:0], "reset value");
    end
    @(posedge clk);
    #1 check(rdata, 8'h00, "read data after answer cycle");
    check(flim, 8'h50, "frequency limit default");
    check(cap, 8'h01, "capture range default");
    reg_wr(ADDR_FREQ_LIMIT, 8'h1E);
    reg_wr(ADDR_CAPTURE_UI, 8'h02);
    #1 check(flim, 8'h1E, "frequency limit write");
    check(cap, 8'h02, "capture range write");
    reg_wr(ADDR_STATUS, 8'hFF);
    reg_wr(8'h20, 8'hFF);
    reg_rd(ADDR_STATUS, got);
    check(got, 8'h08, "status is read only");
    reg_rd(8'h20, got);
    check(got, 8'h00, "unmapped read");
    @(posedge clk);
    foreach (rows[r])
    begin
      // the dead input is never the selected one, so only the slow monitor sees it
      sel <= rows[r].inp;
      reg_wr(ADDR_BUCKET_SIZE, rows[r].size);
      reg_wr(ADDR_UPPER_THR, rows[r].set_thr);
      reg_wr(ADDR_LOWER_THR, rows[r].clr_thr);
      reg_wr(ADDR_DECAY_RATE, {6'h00, rows[r].decay});
      if (rows[r].inp)
        run_two <= 1'b0;
      else
        run_one <= 1'b0;
      wait_bit(rows[r].inp, 1'b1, (rows[r].set_thr - 1) * W,
               (rows[r].set_thr + 1) * W + 8, "alarm raise time");
      check({7'h0, got[rows[r].inp ^ 1'b1]}, 8'h00, "other input alarm");
      repeat (20 * W) @(posedge clk);
      run_one <= 1'b1;
      run_two <= 1'b1;
      n = rows[r].size - rows[r].clr_thr + 1;
      // a bucket that overfilled past its size would need many more leaks
      wait_bit(rows[r].inp, 1'b0, (n - 1) * (32'd1 << rows[r].decay) * W,
               (n * (32'd1 << rows[r].decay) + 1) * W + 8,
               "alarm clear time");
      repeat (40 * W) @(posedge clk);
    end
    reg_wr(ADDR_PERIOD_LO, 8'h04);
    reg_wr(ADDR_PERIOD_HI, 8'h00);
    sel <= 1'b1;
    repeat (12) @(posedge clk);
    run_one <= 1'b0;
    wait_los(1'b1, 5, 14, "loss alarm raise");
    reg_rd(ADDR_STATUS, got);
    check(got & 8'h04, 8'h04, "loss alarm in status");
    @(posedge clk);
    run_one <= 1'b1;
    wait_los(1'b0, 1, 10, "loss alarm drop");
    sel <= 1'b0;
    repeat (2) @(posedge clk);
    #1 prev = ref_two;
    repeat (30)
    begin
      @(posedge clk);
      #1 check({7'h0, sref}, {7'h0, prev}, "selected reference follows input");
      check({7'h0, los}, 8'h00, "no loss on switchover");
      prev = ref_two;
    end
    // mid-run reset with input two's alarm and the loss alarm up: everything must return to its reset state
    @(posedge clk);
    run_two <= 1'b0;
    wait_bit(1, 1'b1, 16, 56, "alarm before reset");
    check({7'h0, los}, 8'h01, "loss alarm before reset");
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 check({6'h00, los, hold}, 8'h00, "alarm pins after reset");
    check(flim, 8'h50, "frequency limit after reset");
    check(cap, 8'h01, "capture range after reset");
    reg_rd(ADDR_STATUS, got);
    check(got, 8'h00, "status after reset");
    reg_rd(ADDR_UPPER_THR, got);
    check(got, 8'h06, "set threshold after reset");
    summarize();
  end
endmodule
